/* File: rtl/mcr_drive_mux.sv */
// Purpose: turns the configuration into driver and pin controls
// Assumes: modulation state inputs are synchronous to clk
// Notes:   all outputs registered, one cycle behind their causes
`timescale 1ns/10ps
`default_nettype none
module mcr_drive_mux
    import mcr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    mcr_reg_if.user                   rif,
    input  wire logic                 am_active,
    input  wire logic                 loadmod_active,
    input  wire logic                 passive_target_mode,
    input  wire logic [MOD_IDX_W-1:0] modulation_index_field,
    input  wire logic [RAM_RES_W-1:0] resistive_am_resistance_field,
    output logic      [MOD_IDX_W-1:0] regulator_am_depth_ff,
    output logic                      regulator_am_active_ff,
    output logic                      shaped_am_enable_ff,
    output logic                      resistive_am_active_ff,
    output logic      [RAM_RES_W-1:0] resistive_res_code_ff,
    output logic                      driver_loadmod_active_ff,
    output logic      [RES_CODE_W-1:0] driver_res_code_ff,
    output logic                      driver_high_z_ff,
    output logic                      ext_loadmod_pin_ff,
    output logic                      ext_loadmod_pin_oe_ff
);
    logic                  regulator_am_off;
    logic                  ext_loadmod_polarity;
    logic                  ext_loadmod_out_enable;
    logic                  driver_loadmod_enable;
    logic                  resistive_am_enable;
    logic                  shaped_am_off;
    logic [RES_CODE_W-1:0] nxt_code;

    assign regulator_am_off       = rif.aux_q[REG_AM_OFF_BIT];
    assign ext_loadmod_polarity   = rif.aux_q[EXT_POL_BIT];
    assign ext_loadmod_out_enable = rif.aux_q[EXT_EN_BIT];
    assign driver_loadmod_enable  = rif.aux_q[DRV_LM_EN_BIT];
    assign resistive_am_enable    = rif.aux_q[RESISTIVE_AM_ENABLE_EN_BIT];
    assign shaped_am_off          = rif.aux_q[SHAPED_AM_OFF_BIT];

    // ==========================================================
    // passive load modulation resistance select
    always_comb begin
        nxt_code = CODE_LOWEST;
        if (passive_target_mode && driver_loadmod_enable) begin
            if (loadmod_active) begin
                nxt_code = rif.ptm_q[PTM_MOD_LSB +: RES_CODE_W];
            end else begin
                nxt_code = rif.ptm_q[PTM_UNMOD_LSB +: RES_CODE_W];
            end
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regulator_am_depth_ff  <= '0;
            regulator_am_active_ff <= 1'b0;
            shaped_am_enable_ff    <= 1'b0;
        end else begin
            regulator_am_depth_ff  <= regulator_am_off ? '0 : modulation_index_field;
            regulator_am_active_ff <= !regulator_am_off && am_active;
            shaped_am_enable_ff    <= !shaped_am_off;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resistive_am_active_ff <= 1'b0;
            resistive_res_code_ff  <= '0;
        end else begin
            resistive_am_active_ff <= resistive_am_enable && am_active;
            resistive_res_code_ff  <= resistive_am_enable ? resistive_am_resistance_field : '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            driver_loadmod_active_ff <= 1'b0;
            driver_res_code_ff       <= CODE_LOWEST;
            driver_high_z_ff         <= 1'b0;
        end else begin
            driver_loadmod_active_ff <= passive_target_mode && driver_loadmod_enable;
            driver_res_code_ff       <= nxt_code;
            driver_high_z_ff         <= (nxt_code == CODE_HIGH_Z);
        end
    end

    // disabled pin rests at its inactive level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_loadmod_pin_ff    <= 1'b0;
            ext_loadmod_pin_oe_ff <= 1'b0;
        end else begin
            ext_loadmod_pin_oe_ff <= ext_loadmod_out_enable;
            ext_loadmod_pin_ff    <= (ext_loadmod_out_enable && loadmod_active)
                                     ^ ext_loadmod_polarity;
        end
    end
endmodule // mcr_drive_mux
`default_nettype wire

/* File: rtl/mcr_mod_regs.sv */
// Purpose: holds the two modulation configuration registers
// Assumes: writes arrive as one-cycle strobes
// Notes:   reserved bits are held at zero
`timescale 1ns/10ps
`default_nettype none
module mcr_mod_regs
    import mcr_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    mcr_reg_if.regs   rif
);
    logic [7:0] aux_ff;
    logic [7:0] ptm_ff;

    // ==========================================================
    // storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aux_ff <= AUX_RST;
        end else if (rif.wr_en && rif.wr_aux) begin
            aux_ff <= rif.wr_data & AUX_WMASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptm_ff <= PTM_RST;
        end else if (rif.wr_en && !rif.wr_aux) begin
            ptm_ff <= rif.wr_data;
        end
    end

    assign rif.aux_q = aux_ff;
    assign rif.ptm_q = ptm_ff;
endmodule // mcr_mod_regs
`default_nettype wire

/* File: rtl/mcr_pkg.sv */
// Purpose: constants for the modulation configuration register block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   byte address is four times the register index
package mcr_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] AUX_IDX      = 8'h28;
    localparam logic [7:0] PTM_IDX      = 8'h29;
    localparam logic [7:0] AUX_ADDR     = 8'(AUX_IDX * 4);
    localparam logic [7:0] PTM_ADDR     = 8'(PTM_IDX * 4);
    localparam int         AXI_AW       = 8;
    localparam int         AXI_DW       = 32;
    localparam int         REG_W        = 8;
    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0] AUX_RST      = 8'h10;
    localparam logic [7:0] PTM_RST      = 8'h70;
    localparam logic [7:0] AUX_WMASK    = 8'hFC;
    // ==========================================================
    // auxiliary modulation fields
    localparam int         REG_AM_OFF_BIT   = 7;
    localparam int         EXT_POL_BIT      = 6;
    localparam int         EXT_EN_BIT       = 5;
    localparam int         DRV_LM_EN_BIT    = 4;
    localparam int         RESISTIVE_AM_ENABLE_EN_BIT    = 3;
    localparam int         SHAPED_AM_OFF_BIT = 2;
    // ==========================================================
    // passive target fields and resistance code
    localparam int         PTM_MOD_LSB  = 4;
    localparam int         PTM_UNMOD_LSB = 0;
    localparam int         RES_CODE_W   = 4;
    localparam logic [3:0] CODE_HIGH_Z  = 4'hF;
    localparam logic [3:0] CODE_LOWEST  = 4'h0;
    localparam int         MOD_IDX_W    = 4;
    localparam int         RAM_RES_W    = 7;
    // ==========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {
        MCR_W_IDLE = 2'b01,
        MCR_W_RESP = 2'b10
    } mcr_wstate_t;
    typedef enum logic [1:0] {
        MCR_R_IDLE = 2'b01,
        MCR_R_DATA = 2'b10
    } mcr_rstate_t;
endpackage

/* File: rtl/mcr_reg_if.sv */
// Purpose: carries register writes and register contents between modules
// Assumes: single clock
// Notes:   write strobe is one cycle wide
`timescale 1ns/10ps
`default_nettype none
interface mcr_reg_if;
    logic       wr_en;
    logic       wr_aux;
    logic [7:0] wr_data;
    logic [7:0] aux_q;
    logic [7:0] ptm_q;
    modport master (output wr_en, output wr_aux, output wr_data, input aux_q, input ptm_q);
    modport regs   (input wr_en, input wr_aux, input wr_data, output aux_q, output ptm_q);
    modport user   (input aux_q, input ptm_q);
endinterface
`default_nettype wire

/* File: rtl/mcr_top.sv */
// Purpose: modulation configuration registers behind an AXI4-Lite slave
// Assumes: one write and one read outstanding at most
// Notes:   registers sit at four times their index; upper data bits read zero
//
// Functional notes
// - aux bit 7 low enables regulator AM using modulation index; resets 0.
// - aux bit 6 chooses pin polarity: 0 active high, 1 active low.
// - aux bit 5 drives load modulation onto external pin; resets 0.
// - aux bit 4 enables driver load modulation from passive register; resets 1.
// - aux bit 3 enables resistive AM using separate 7-bit resistance field.
// - passive bits 7..4 modulated resistance, bits 3..0 unmodulated resistance.
// - codes 0..14 rise in resistance, 15 high impedance; resets 0111/0000.
`timescale 1ns/10ps
`default_nettype none
module mcr_top
    import mcr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [AXI_DW-1:0]     s_axi_wdata,
    input  wire logic [AXI_DW/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AXI_AW-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [AXI_DW-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  am_active,
    input  wire logic                  loadmod_active,
    input  wire logic                  passive_target_mode,
    input  wire logic [MOD_IDX_W-1:0]  modulation_index_field,
    input  wire logic [RAM_RES_W-1:0]  resistive_am_resistance_field,
    output logic [MOD_IDX_W-1:0]       regulator_am_depth,
    output logic                       regulator_am_active,
    output logic                       shaped_am_enable,
    output logic                       resistive_am_active,
    output logic [RAM_RES_W-1:0]       resistive_res_code,
    output logic                       driver_loadmod_active,
    output logic [RES_CODE_W-1:0]      driver_res_code,
    output logic                       driver_high_z,
    output logic                       external_loadmod_pin_o,
    output logic                       external_loadmod_pin_oe
);
    mcr_reg_if rif ();

    mcr_wstate_t        wstate_ff;
    mcr_rstate_t        rstate_ff;
    logic               awready_ff;
    logic               wready_ff;
    logic               bvalid_ff;
    logic [1:0]         bresp_ff;
    logic               arready_ff;
    logic               rvalid_ff;
    logic [1:0]         rresp_ff;
    logic [AXI_DW-1:0]  rdata_ff;
    logic               have_aw_ff;
    logic               have_w_ff;
    logic [AXI_AW-1:0]  awaddr_ff;
    logic [7:0]         wdata_ff;
    logic               wlane_ff;
    logic               write_go;
    logic               w_hit_aux;
    logic               w_hit_ptm;
    logic [7:0]         rd_byte;
    logic               r_hit;

    // ==========================================================
    // write channel capture
    assign write_go  = (wstate_ff == MCR_W_IDLE) && have_aw_ff && have_w_ff;
    assign w_hit_aux = (awaddr_ff == AUX_ADDR);
    assign w_hit_ptm = (awaddr_ff == PTM_ADDR);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            have_aw_ff <= 1'b0;
            awaddr_ff  <= '0;
            awready_ff <= 1'b1;
        end else if (s_axi_awvalid && awready_ff) begin
            have_aw_ff <= 1'b1;
            awaddr_ff  <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
            awready_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            have_aw_ff <= 1'b0;
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            have_w_ff <= 1'b0;
            wdata_ff  <= '0;
            wlane_ff  <= 1'b0;
            wready_ff <= 1'b1;
        end else if (s_axi_wvalid && wready_ff) begin
            have_w_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wlane_ff  <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            have_w_ff <= 1'b0;
            wready_ff <= 1'b1;
        end
    end

    // ==========================================================
    // write response
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wstate_ff <= MCR_W_IDLE;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else begin
            case (wstate_ff)
                MCR_W_IDLE: begin
                    if (write_go) begin
                        bvalid_ff <= 1'b1;
                        bresp_ff  <= (w_hit_aux || w_hit_ptm) ? RESP_OKAY : RESP_SLVERR;
                        wstate_ff <= MCR_W_RESP;
                    end
                end
                MCR_W_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_ff <= 1'b0;
                        wstate_ff <= MCR_W_IDLE;
                    end
                end
                default: begin
                    bvalid_ff <= 1'b0;
                    wstate_ff <= MCR_W_IDLE;
                end
            endcase
        end
    end

    assign rif.wr_en   = write_go && wlane_ff && (w_hit_aux || w_hit_ptm);
    assign rif.wr_aux  = w_hit_aux;
    assign rif.wr_data = wdata_ff;

    // ==========================================================
    // read channel
    always_comb begin
        r_hit   = 1'b1;
        rd_byte = '0;
        if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == AUX_ADDR) begin
            rd_byte = rif.aux_q & AUX_WMASK;
        end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == PTM_ADDR) begin
            rd_byte = rif.ptm_q;
        end else begin
            r_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rstate_ff  <= MCR_R_IDLE;
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= '0;
        end else begin
            case (rstate_ff)
                MCR_R_IDLE: begin
                    if (s_axi_arvalid) begin
                        arready_ff <= 1'b0;
                        rvalid_ff  <= 1'b1;
                        rresp_ff   <= r_hit ? RESP_OKAY : RESP_SLVERR;
                        rdata_ff   <= {{(AXI_DW-REG_W){1'b0}}, rd_byte};
                        rstate_ff  <= MCR_R_DATA;
                    end
                end
                MCR_R_DATA: begin
                    if (s_axi_rready) begin
                        rvalid_ff  <= 1'b0;
                        arready_ff <= 1'b1;
                        rstate_ff  <= MCR_R_IDLE;
                    end
                end
                default: begin
                    rvalid_ff  <= 1'b0;
                    arready_ff <= 1'b1;
                    rstate_ff  <= MCR_R_IDLE;
                end
            endcase
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;

    // ==========================================================
    // storage and driver control
    mcr_mod_regs u_regs (
        .clk   (clk),
        .reset (reset),
        .rif   (rif)
    );

    mcr_drive_mux u_mux (
        .clk                           (clk),
        .reset                         (reset),
        .rif                           (rif),
        .am_active                     (am_active),
        .loadmod_active                (loadmod_active),
        .passive_target_mode           (passive_target_mode),
        .modulation_index_field        (modulation_index_field),
        .resistive_am_resistance_field (resistive_am_resistance_field),
        .regulator_am_depth_ff         (regulator_am_depth),
        .regulator_am_active_ff        (regulator_am_active),
        .shaped_am_enable_ff           (shaped_am_enable),
        .resistive_am_active_ff        (resistive_am_active),
        .resistive_res_code_ff         (resistive_res_code),
        .driver_loadmod_active_ff      (driver_loadmod_active),
        .driver_res_code_ff            (driver_res_code),
        .driver_high_z_ff              (driver_high_z),
        .ext_loadmod_pin_ff            (external_loadmod_pin_o),
        .ext_loadmod_pin_oe_ff         (external_loadmod_pin_oe)
    );
endmodule // mcr_top
`default_nettype wire

/* File: test/mcr_top_chk.sv */
// Purpose: port level checks of the modulation configuration block
// Assumes: register contents are mirrored from completed AXI writes
// Notes:   the mirror trails the registers by one clock, as the outputs do
`timescale 1ns/10ps
`default_nettype none
module mcr_top_chk
    import mcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        am_active,
    input wire logic        loadmod_active,
    input wire logic        passive_target_mode,
    input wire logic [3:0]  modulation_index_field,
    input wire logic [6:0]  resistive_am_resistance_field,
    input wire logic [3:0]  regulator_am_depth,
    input wire logic        regulator_am_active,
    input wire logic        shaped_am_enable,
    input wire logic        resistive_am_active,
    input wire logic [6:0]  resistive_res_code,
    input wire logic        driver_loadmod_active,
    input wire logic [3:0]  driver_res_code,
    input wire logic        driver_high_z,
    input wire logic        external_loadmod_pin_o,
    input wire logic        external_loadmod_pin_oe
);
    // ==========================================================
    // register mirror
    logic [7:0] aw_a_ff, w_d_ff, ax_ff, pt_ff;
    logic       w_s_ff, bv_ff, age_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {aw_a_ff, w_d_ff, w_s_ff, bv_ff, age_ff} <= '0;
            ax_ff <= 8'h10;
            pt_ff <= 8'h70;
        end else begin
            age_ff <= 1'b1;
            bv_ff  <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) aw_a_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) {w_s_ff, w_d_ff} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            if (s_axi_bvalid && !bv_ff && s_axi_bresp == RESP_OKAY && w_s_ff) begin
                if (aw_a_ff[7:2] == AUX_ADDR[7:2]) ax_ff <= w_d_ff & 8'hFC;
                if (aw_a_ff[7:2] == PTM_ADDR[7:2]) pt_ff <= w_d_ff;
            end
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reg_am_follow: assert property (age_ff |->
        regulator_am_depth == (ax_ff[7] ? 4'h0 : $past(modulation_index_field))
        && regulator_am_active == (!ax_ff[7] && $past(am_active))) else $error("regulator am wrong");
    a_pin_level: assert property (age_ff |->
        external_loadmod_pin_o == ((ax_ff[5] && $past(loadmod_active)) ^ ax_ff[6]))
        else $error("pin level wrong");
    a_pin_enable: assert property (age_ff |-> external_loadmod_pin_oe == ax_ff[5])
        else $error("pin enable wrong");
    a_drv_active: assert property (age_ff |->
        driver_loadmod_active == (ax_ff[4] && $past(passive_target_mode)))
        else $error("driver state wrong");
    a_resistive_am_enable_follow: assert property (age_ff |->
        resistive_am_active == (ax_ff[3] && $past(am_active)) && resistive_res_code ==
        (ax_ff[3] ? $past(resistive_am_resistance_field) : 7'h00)) else $error("resistive am wrong");
    a_shaped_am: assert property (age_ff |-> shaped_am_enable != ax_ff[2])
        else $error("shaped am enable wrong");
    a_drv_code: assert property (age_ff |-> driver_res_code ==
        (!(ax_ff[4] && $past(passive_target_mode)) ? 4'h0 : $past(loadmod_active) ? pt_ff[7:4]
        : pt_ff[3:0])) else $error("driver code wrong");
    a_high_z: assert property (driver_high_z == (driver_res_code == CODE_HIGH_Z))
        else $error("high z flag wrong");
    c_pin_inverted: cover property (external_loadmod_pin_oe && ax_ff[6] && $past(loadmod_active));
    c_high_z: cover property (driver_high_z && driver_loadmod_active);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // mcr_top_chk

bind mcr_top mcr_top_chk u_chk (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .am_active, .loadmod_active,
    .passive_target_mode, .modulation_index_field, .resistive_am_resistance_field,
    .regulator_am_depth, .regulator_am_active, .shaped_am_enable, .resistive_am_active,
    .resistive_res_code, .driver_loadmod_active, .driver_res_code, .driver_high_z,
    .external_loadmod_pin_o, .external_loadmod_pin_oe
);
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: directed tests of the modulation configuration block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   expected outputs follow the written register fields
`timescale 1ns/10ps
`default_nettype none
module testbench
    import mcr_pkg::*;
;
    logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, am_active, loadmod_active, passive_target_mode;
    logic        regulator_am_active, shaped_am_enable, resistive_am_active, driver_high_z;
    logic        driver_loadmod_active, external_loadmod_pin_o, external_loadmod_pin_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  s_axi_wstrb, modulation_index_field, regulator_am_depth, driver_res_code;
    logic [6:0]  resistive_am_resistance_field, resistive_res_code;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ax, pt;
    logic [15:0] tbl [8];
    logic [21:0] outs;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    int          num_errors, checks_done;

    mcr_top dut (
        .clk, .reset, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .am_active, .loadmod_active,
        .passive_target_mode, .modulation_index_field, .resistive_am_resistance_field,
        .regulator_am_depth, .regulator_am_active, .shaped_am_enable, .resistive_am_active,
        .resistive_res_code, .driver_loadmod_active, .driver_res_code, .driver_high_z,
        .external_loadmod_pin_o, .external_loadmod_pin_oe);

    assign outs = {regulator_am_depth, regulator_am_active, shaped_am_enable, resistive_am_active,
                   resistive_res_code, driver_loadmod_active, driver_res_code, driver_high_z,
                   external_loadmod_pin_o, external_loadmod_pin_oe};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // bus and compare tasks
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {rsp, rd} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask

    // drive state inputs, compare every output
    task automatic apply(input logic [7:0] x, input logic [7:0] y, input logic [3:0] j);
        logic [3:0]  c;
        logic [21:0] e;
        @(posedge clk);
        {passive_target_mode, loadmod_active, am_active} <= {j[1], j[0], j[1] ^ j[0]};
        {modulation_index_field, resistive_am_resistance_field} <= {y, 3'h5};
        repeat (2) @(posedge clk);
        #1;
        c = (x[4] && passive_target_mode) ? (loadmod_active ? y[7:4] : y[3:0]) : 4'h0;
        e = {x[7] ? 4'h0 : modulation_index_field, !x[7] && am_active, !x[2], x[3] && am_active,
             x[3] ? resistive_am_resistance_field : 7'h00, x[4] && passive_target_mode, c,
             c == 4'hF, (x[5] && loadmod_active) ^ x[6], x[5]};
        chk(32'(outs[21:8]), 32'(e[21:8]));
        chk(32'(outs[7:0]), 32'(e[7:0]));
    endtask
    // ==========================================================
    // tests
    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {am_active, loadmod_active, passive_target_mode} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        modulation_index_field = 4'hA;
        resistive_am_resistance_field = 7'h55;
        tbl = '{16'h0000, 16'h23F3, 16'h620E, 16'h4181, 16'h98E7, 16'h14FF, 16'hFF3C, 16'h347F};
        num_errors = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdr(AUX_ADDR);
        chk(rd, 32'h0000_0010);
        rdr(PTM_ADDR);
        chk(rd, 32'h0000_0070);
        for (int j = 0; j < 4; j++) apply(8'h10, 8'h70, 4'(3 - j));
        for (int i = 0; i < 8; i++) begin
            {ax, pt} = tbl[i];
            wr(AUX_ADDR, {24'hFFFFFF, ax}, 4'hF);
            chk(32'(rsp), 32'(RESP_OKAY));
            wr(PTM_ADDR, {24'h0, pt}, 4'h1);
            rdr(AUX_ADDR);
            chk(rd, {24'h0, ax & 8'hFC});
            rdr(PTM_ADDR);
            chk(rd, {24'h0, pt});
            for (int j = 0; j < 4; j++) apply(ax & 8'hFC, pt, 4'(3 - j));
        end
        wr(8'h00, 32'h0000_00FF, 4'hF);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(PTM_ADDR, 32'h0000_0011, 4'hE);
        rdr(8'hFC);
        chk(32'(rsp), 32'(RESP_SLVERR));
        chk(rd, 32'h0);
        rdr(PTM_ADDR);
        chk(rd, {24'h0, pt});
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
